/* rtl/rtu_pkg.sv */
// Constants of the reader timer unit and its interrupt flags.
// Assumes a single 125 MHz system clock; timer rates are made by phase accumulators.
package rtu_pkg;
  // Clock rates in Hz
  localparam longint CLK_HZ = 125000000;
  localparam longint FAST_HZ = 13560000;
  localparam longint SLOW_HZ = 212000;
  localparam int ACC_W = 24;
  localparam logic [23:0] FAST_INC = 24'((FAST_HZ << ACC_W) / CLK_HZ);
  localparam logic [23:0] SLOW_INC = 24'((SLOW_HZ << ACC_W) / CLK_HZ);
  localparam logic [23:0] ACC_RST = 24'h000000;
  // Clock source select codes
  localparam logic [1:0] SEL_FAST = 2'h0;
  localparam logic [1:0] SEL_SLOW = 2'h1;
  localparam logic [1:0] SEL_WAKE = 2'h2;
  // Counter
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // Flag register a bit positions
  localparam int FA_TX = 0;
  localparam int FA_RX = 1;
  localparam int FA_CMD = 2;
  localparam int FA_HIGH = 3;
  localparam int FA_LOW = 4;
  localparam int FA_ERR = 5;
  localparam int FA_SOF = 6;
  // Flag register b bit positions
  localparam int FB_T0 = 0;
  localparam int FB_CARD = 4;
  localparam int FB_WAKE = 5;
  localparam int FB_GLOBAL = 6;
  // Bit 7 of a write selects set (1) or clear (0) of bits 0 to 6
  localparam int WR_SET_BIT = 7;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  // Control write layout: bits 0-3 select the timers to update, bits 4-7 running value
  localparam int CTL_RUN_LSB = 4;
endpackage

/* rtl/rtu_timer_unit.sv */
// Timer unit with four general down-counters, a wake-up timer and the interrupt flags.
// Assumes all inputs are synchronous to clk_sys and that strobes are one-cycle pulses.
`timescale 1ns/10ps
module rtu_timer_unit #(
  parameter int NT = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Shared timer control write
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  // Per-timer configuration
  input wire logic [2*NT-1:0] clk_sel,
  input wire logic [NT-1:0] timer_auto_reload,
  input wire logic [8*NT-1:0] timer_reload_high,
  input wire logic [8*NT-1:0] timer_reload_low,
  input wire logic [NT-1:0] mode_start,
  input wire logic [NT-1:0] wait_start_evt,
  input wire logic [NT-1:0] use_stop_evt,
  input wire logic [NT-1:0] start_evt,
  input wire logic [NT-1:0] stop_evt,
  // Wake-up timer
  input wire logic slow_oscillator,
  input wire logic wake_start,
  input wire logic wake_stop,
  input wire logic wake_timer_auto_reload,
  input wire logic wake_timer_auto_standby,
  input wire logic [7:0] wake_reload_high,
  input wire logic [7:0] wake_reload_low,
  input wire logic enter_standby,
  input wire logic detect_done,
  input wire logic card_present,
  // Events from neighbouring units
  input wire logic transmit_done,
  input wire logic receive_done,
  input wire logic command_done,
  input wire logic fifo_high_mark,
  input wire logic fifo_low_mark,
  input wire logic receive_error,
  input wire logic frame_start_seen,
  // Flag and enable writes
  input wire logic flag_a_wr,
  input wire logic flag_b_wr,
  input wire logic en_a_wr,
  input wire logic en_b_wr,
  input wire logic [7:0] flag_wdata,
  // Status
  output logic [NT-1:0] timer_running,
  output logic [8*NT-1:0] timer_count_high,
  output logic [8*NT-1:0] timer_count_low,
  output logic [15:0] wake_count,
  output logic wake_running,
  output logic [7:0] flag_register_a,
  output logic [7:0] flag_register_b,
  output logic [7:0] flag_enable_a,
  output logic [7:0] flag_enable_b,
  output logic standby,
  output logic irq
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Rate ticks: fractional accumulators, so tick spacing jitters by one cycle
  logic [23:0] acc_f_q, acc_f_d, acc_s_q, acc_s_d;
  logic fast_q, fast_d, slow_q, slow_d;

  always_comb
  begin
    {fast_d, acc_f_d} = {1'b0, acc_f_q} + {1'b0, rtu_pkg::FAST_INC};
    {slow_d, acc_s_d} = {1'b0, acc_s_q} + {1'b0, rtu_pkg::SLOW_INC};
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_f_q <= rtu_pkg::ACC_RST;
      acc_s_q <= rtu_pkg::ACC_RST;
      fast_q <= 1'b0;
      slow_q <= 1'b0;
    end
    else
    begin
      acc_f_q <= acc_f_d;
      acc_s_q <= acc_s_d;
      fast_q <= fast_d;
      slow_q <= slow_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake-up timer and standby control
  logic [15:0] wcnt_q, wcnt_d;
  logic wrun_q, wrun_d, wuf, sb_q, sb_d;
  logic [15:0] wreload;

  assign wreload = {wake_reload_high, wake_reload_low};
  assign wuf = wrun_q && slow_oscillator && (wcnt_q == rtu_pkg::COUNT_ZERO);

  always_comb
  begin
    wcnt_d = wcnt_q;
    wrun_d = wrun_q;
    sb_d = sb_q;
    if (wake_start)
    begin
      wrun_d = 1'b1;
      wcnt_d = wreload;
    end
    else if (wake_stop)
      wrun_d = 1'b0;
    else if (wuf)
    begin
      wrun_d = wake_timer_auto_reload;
      wcnt_d = wake_timer_auto_reload ? wreload : rtu_pkg::COUNT_ZERO;
    end
    else if (wrun_q && slow_oscillator)
      wcnt_d = wcnt_q - rtu_pkg::COUNT_ONE;
    if (wuf)
      sb_d = 1'b0;
    else if (enter_standby)
      sb_d = 1'b1;
    else if (detect_done && !card_present && !sb_q)
      sb_d = wake_timer_auto_standby;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wcnt_q <= rtu_pkg::COUNT_RST;
      wrun_q <= 1'b0;
      sb_q <= 1'b0;
    end
    else
    begin
      wcnt_q <= wcnt_d;
      wrun_q <= wrun_d;
      sb_q <= sb_d;
    end
  end

  chk_wake_exit: assert property (wuf |=> !sb_q)
    else $error("standby not left on wake expiry");
  chk_stay_awake: assert property (detect_done && !card_present && !sb_q && !enter_standby
    && !wuf && !wake_timer_auto_standby |=> !sb_q)
    else $error("standby entered without auto standby");

  ////////////////////////////////////////////////////////////////////////////////
  // General timers
  // Flag state is declared here because the per-timer checks below watch it
  logic [7:0] flag_a_q, flag_a_d, flag_b_q, flag_b_d, en_a_q, en_a_d, en_b_q, en_b_d;
  logic [15:0] cnt_q [NT], cnt_d [NT];
  logic [NT-1:0] run_q, run_d, arm_q, arm_d, tick, uf, host_go;

  always_comb
  begin
    run_d = run_q;
    arm_d = arm_q;
    for (int i = 0; i < NT; i++)
    begin
      cnt_d[i] = cnt_q[i];
      case (clk_sel[2*i +: 2])
        rtu_pkg::SEL_FAST: tick[i] = fast_q;
        rtu_pkg::SEL_SLOW: tick[i] = slow_q;
        rtu_pkg::SEL_WAKE: tick[i] = wuf;
        default: tick[i] = 1'b0;
      endcase
      uf[i] = run_q[i] && tick[i] && (cnt_q[i] == rtu_pkg::COUNT_ZERO);
      host_go[i] = (ctl_wr && ctl_wdata[i] && ctl_wdata[rtu_pkg::CTL_RUN_LSB + i])
        || mode_start[i];
      if (host_go[i])
      begin
        cnt_d[i] = {timer_reload_high[8*i +: 8], timer_reload_low[8*i +: 8]};
        arm_d[i] = wait_start_evt[i] && !start_evt[i];
        run_d[i] = !arm_d[i];
      end
      else if (ctl_wr && ctl_wdata[i])
      begin
        run_d[i] = 1'b0;
        arm_d[i] = 1'b0;
      end
      else if (arm_q[i] && start_evt[i])
      begin
        arm_d[i] = 1'b0;
        run_d[i] = 1'b1;
      end
      else if (run_q[i] && use_stop_evt[i] && stop_evt[i])
        run_d[i] = 1'b0;
      else if (uf[i])
      begin
        run_d[i] = timer_auto_reload[i];
        if (timer_auto_reload[i])
          cnt_d[i] = {timer_reload_high[8*i +: 8], timer_reload_low[8*i +: 8]};
      end
      else if (run_q[i] && tick[i])
        cnt_d[i] = cnt_q[i] - rtu_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= '0;
      arm_q <= '0;
      for (int i = 0; i < NT; i++)
        cnt_q[i] <= rtu_pkg::COUNT_RST;
    end
    else
    begin
      run_q <= run_d;
      arm_q <= arm_d;
      for (int i = 0; i < NT; i++)
        cnt_q[i] <= cnt_d[i];
    end
  end

  for (genvar g = 0; g < NT; g++)
  begin : g_chk
    logic quiet;
    assign quiet = !ctl_wr && !mode_start[g] && !(use_stop_evt[g] && stop_evt[g]);
    chk_count_dec: assert property (run_q[g] && tick[g] && quiet
      && cnt_q[g] != rtu_pkg::COUNT_ZERO |=> cnt_q[g] == $past(cnt_q[g]) - 16'h0001)
      else $error("counter did not decrement");
    chk_reload_run: assert property (uf[g] && quiet && timer_auto_reload[g]
      |=> run_q[g] && cnt_q[g] == {timer_reload_high[8*g +: 8], timer_reload_low[8*g +: 8]})
      else $error("no reload at underflow");
    chk_halt_zero: assert property (uf[g] && quiet && !timer_auto_reload[g]
      |=> !run_q[g] && cnt_q[g] == rtu_pkg::COUNT_ZERO)
      else $error("timer did not halt at zero");
    chk_stop_hold: assert property (run_q[g] && use_stop_evt[g] && stop_evt[g] && !ctl_wr
      && !mode_start[g] |=> !run_q[g] ##1 $stable(cnt_q[g]))
      else $error("stop event did not hold count");
    chk_flag_uf: assert property (uf[g] |=> flag_b_q[rtu_pkg::FB_T0 + g])
      else $error("underflow flag missing");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and enables; hardware set wins over a host clear in the same cycle
  logic [7:0] hw_a, hw_b;
  logic glob_d, irq_q, irq_d;

  // Applies a bit-7 qualified write to bits 0 to 6
  function automatic logic [7:0] wr_flags(input logic [7:0] cur, input logic we,
                                          input logic [7:0] wd);
    logic [7:0] r;
    r = cur;
    if (we)
      r[6:0] = wd[rtu_pkg::WR_SET_BIT] ? (cur[6:0] | wd[6:0]) : (cur[6:0] & ~wd[6:0]);
    r[7] = 1'b0;
    return r;
  endfunction

  always_comb
  begin
    hw_a = 8'h00;
    hw_a[rtu_pkg::FA_TX] = transmit_done;
    hw_a[rtu_pkg::FA_RX] = receive_done;
    hw_a[rtu_pkg::FA_CMD] = command_done;
    hw_a[rtu_pkg::FA_HIGH] = fifo_high_mark;
    hw_a[rtu_pkg::FA_LOW] = fifo_low_mark;
    hw_a[rtu_pkg::FA_ERR] = receive_error;
    hw_a[rtu_pkg::FA_SOF] = frame_start_seen;
    hw_b = 8'h00;
    hw_b[rtu_pkg::FB_T0 +: NT] = uf;
    hw_b[rtu_pkg::FB_CARD] = detect_done && card_present;
    hw_b[rtu_pkg::FB_WAKE] = wuf;
    flag_a_d = wr_flags(flag_a_q, flag_a_wr, flag_wdata) | hw_a;
    flag_b_d = wr_flags(flag_b_q, flag_b_wr, flag_wdata) | hw_b;
    glob_d = |(flag_a_q[6:0] & en_a_q[6:0]) | |(flag_b_q[5:0] & en_b_q[5:0]);
    flag_b_d[rtu_pkg::FB_GLOBAL] = glob_d;
    en_a_d = wr_flags(en_a_q, en_a_wr, flag_wdata);
    en_b_d = wr_flags(en_b_q, en_b_wr, flag_wdata);
    irq_d = flag_b_q[rtu_pkg::FB_GLOBAL] && en_b_q[rtu_pkg::FB_GLOBAL];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_a_q <= rtu_pkg::FLAG_RST;
      flag_b_q <= rtu_pkg::FLAG_RST;
      en_a_q <= rtu_pkg::ENABLE_RST;
      en_b_q <= rtu_pkg::ENABLE_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      flag_a_q <= flag_a_d;
      flag_b_q <= flag_b_d;
      en_a_q <= en_a_d;
      en_b_q <= en_b_d;
      irq_q <= irq_d;
    end
  end

  chk_set_wins: assert property (transmit_done && flag_a_wr && !flag_wdata[7]
    |=> flag_a_q[rtu_pkg::FA_TX])
    else $error("event lost against clear");
  chk_flag_sticky: assert property (flag_b_q[0] && !flag_b_wr |=> flag_b_q[0])
    else $error("timer flag dropped without clear");
  chk_global_set: assert property (flag_a_q[0] && en_a_q[0] |=> flag_b_q[6])
    else $error("global flag not set");
  chk_irq_pin: assert property (flag_b_q[0] && en_b_q[0] && en_b_q[6] && !flag_b_wr
    && !en_b_wr |-> ##[1:2] irq_q)
    else $error("interrupt pin not raised");

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb
  begin
    for (int i = 0; i < NT; i++)
    begin
      timer_count_high[8*i +: 8] = cnt_q[i][15:8];
      timer_count_low[8*i +: 8] = cnt_q[i][7:0];
    end
  end

  assign timer_running = run_q;
  assign wake_count = wcnt_q;
  assign wake_running = wrun_q;
  assign flag_register_a = flag_a_q;
  assign flag_register_b = flag_b_q;
  assign flag_enable_a = en_a_q;
  assign flag_enable_b = en_b_q;
  assign standby = sb_q;
  assign irq = irq_q;

endmodule

/* bench/test_reader_timer_unit_irq_flags.sv */
// Self-checking bench for the reader timer unit and its interrupt flags.
// Assumes rtu_timer_unit with NT=4, rtu_pkg constants and a 125 MHz clk_sys.
`timescale 1ns/10ps
module test_reader_timer_unit_irq_flags;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h1;
  logic ctl_wr = 1'h0;
  logic [7:0] ctl_wdata = 8'h00;
  logic [7:0] clk_sel = 8'h00;
  logic [3:0] timer_auto_reload = 4'h0;
  logic [31:0] timer_reload_high = 32'h0;
  logic [31:0] timer_reload_low = 32'h0;
  logic [3:0] mode_start = 4'h0, wait_start_evt = 4'h0, use_stop_evt = 4'h0;
  logic [3:0] start_evt = 4'h0, stop_evt = 4'h0;
  logic slow_oscillator = 1'h0, osc_on = 1'h0, wake_start = 1'h0, wake_stop = 1'h0;
  logic wake_timer_auto_reload = 1'h0, wake_timer_auto_standby = 1'h0;
  logic [7:0] wake_reload_high = 8'h00, wake_reload_low = 8'h02;
  logic enter_standby = 1'h0, detect_done = 1'h0, card_present = 1'h0;
  logic [6:0] ev = 7'h00;
  logic flag_a_wr = 1'h0, flag_b_wr = 1'h0, en_a_wr = 1'h0, en_b_wr = 1'h0;
  logic [7:0] flag_wdata = 8'h00;
  logic [3:0] timer_running;
  logic [31:0] timer_count_high, timer_count_low;
  logic [15:0] wake_count;
  logic wake_running, standby, irq;
  logic [7:0] flag_register_a, flag_register_b, flag_enable_a, flag_enable_b;
  int err_total = 0;
  int checked = 0;
  logic [7:0] exp_a, r8;
  logic [15:0] rl, held;
  ////////////////////////////////////////////////////////////////////////////////
  rtu_timer_unit #(.NT(4)) DUT (
    .clk_sys, .rst_n, .ctl_wr, .ctl_wdata, .clk_sel, .timer_auto_reload,
    .timer_reload_high, .timer_reload_low, .mode_start, .wait_start_evt,
    .use_stop_evt, .start_evt, .stop_evt, .slow_oscillator, .wake_start, .wake_stop,
    .wake_timer_auto_reload, .wake_timer_auto_standby, .wake_reload_high,
    .wake_reload_low, .enter_standby, .detect_done, .card_present,
    .transmit_done(ev[0]), .receive_done(ev[1]), .command_done(ev[2]),
    .fifo_high_mark(ev[3]), .fifo_low_mark(ev[4]), .receive_error(ev[5]),
    .frame_start_seen(ev[6]), .flag_a_wr, .flag_b_wr, .en_a_wr, .en_b_wr,
    .flag_wdata, .timer_running, .timer_count_high, .timer_count_low, .wake_count,
    .wake_running, .flag_register_a, .flag_register_b, .flag_enable_a,
    .flag_enable_b, .standby, .irq
  );
  always #4 clk_sys = ~clk_sys;
  // Slow oscillator stands in as one tick every other cycle to keep the run short
  always @(posedge clk_sys) slow_oscillator <= osc_on & ~slow_oscillator;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] cnt(input int t);
    return {timer_count_high[8*t+:8], timer_count_low[8*t+:8]};
  endfunction
  function automatic logic [7:0] fl_next(input logic [7:0] old, input logic [7:0] d);
    return d[7] ? (old | {1'h0, d[6:0]}) : (old & ~{1'h0, d[6:0]});
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Kinds: 0 control, 1 flag a, 2 flag b, 3 enable a, 4 enable b
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge clk_sys);
    flag_wdata <= d;
    ctl_wdata <= d;
    case (k)
      0: ctl_wr <= 1'h1;
      1: flag_a_wr <= 1'h1;
      2: flag_b_wr <= 1'h1;
      3: en_a_wr <= 1'h1;
      default: en_b_wr <= 1'h1;
    endcase
    cyc(1);
    {ctl_wr, flag_a_wr, flag_b_wr, en_a_wr, en_b_wr} <= 5'h00;
  endtask
  task automatic pulse(input int k, input int i);
    @(posedge clk_sys);
    case (k)
      0: ev[i] <= 1'h1;
      1: mode_start[i] <= 1'h1;
      2: start_evt[i] <= 1'h1;
      3: stop_evt[i] <= 1'h1;
      4: enter_standby <= 1'h1;
      5: wake_start <= 1'h1;
      default: detect_done <= 1'h1;
    endcase
    cyc(1);
    ev <= 7'h00;
    {mode_start, start_evt, stop_evt} <= 12'h000;
    {enter_standby, wake_start, detect_done} <= 3'h0;
  endtask
  // Below 8 waits for a flag_b bit, from 8 up for a timer to stop running
  task automatic wait_for(input int w, input int lim);
    int n;
    n = 0;
    while ((w < 8 ? flag_register_b[w] !== 1'h1 : timer_running[w-8] !== 1'h0) && n < lim)
    begin
      cyc(1);
      n++;
    end
    if (n >= lim)
    begin
      err_total++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    r8 = 8'($urandom(32'h3246));
    // A real falling edge, so the asynchronous reset branches do fire
    rst_n <= 1'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    cyc(1);
    check({flag_register_a, flag_register_b}, 16'h0000);
    check({timer_running, standby, irq}, 16'h0000);
    exp_a = 8'h00;
    for (int k = 0; k < 6; k++)
    begin
      r8 = 8'($urandom);
      wr(1, r8);
      exp_a = fl_next(exp_a, r8);
      check(flag_register_a, exp_a);
    end
    wr(2, 8'h81);
    check(flag_register_b[0], 1'h1);
    wr(2, 8'h01);
    check(flag_register_b[0], 1'h0);
    // Sources without enables must not reach the global flag
    wr(1, 8'hFF);
    cyc(2);
    check(flag_register_b[6], 1'h0);
    wr(4, 8'hC0);
    check(flag_enable_b, 8'h40);
    wr(3, 8'h81);
    check(flag_enable_a, 8'h01);
    cyc(1);
    check(flag_register_b[6], 1'h1);
    cyc(1);
    check(irq, 1'h1);
    wr(1, 8'h7F);
    check(flag_register_a, 8'h00);
    cyc(2);
    check({flag_register_b[6], irq}, 2'h0);
    for (int i = 0; i < 7; i++)
    begin
      pulse(0, i);
      check(flag_register_a, 8'h01 << i);
      wr(1, 8'h7F);
    end
    // One-shot on timer 0 from the fast clock
    rl = 16'h0002 + 16'($urandom_range(8));
    @(posedge clk_sys);
    timer_reload_low[7:0] <= rl[7:0];
    wr(0, 8'h11);
    check(timer_running[0], 1'h1);
    check(cnt(0), rl);
    for (int n = 0; n < 40 && cnt(0) == rl; n++) cyc(1);
    check(cnt(0), rl - 16'h0001);
    wait_for(8, 400);
    check(cnt(0), 16'h0000);
    check(flag_register_b[0], 1'h1);
    cyc(50);
    check(flag_register_b[0], 1'h1);
    wr(2, 8'h01);
    // Periodic trigger on timer 1
    @(posedge clk_sys);
    timer_reload_low[15:8] <= 8'h05;
    timer_auto_reload[1] <= 1'h1;
    wr(0, 8'h22);
    wait_for(1, 300);
    check(timer_running[1], 1'h1);
    wr(2, 8'h02);
    check(flag_register_b[1], 1'h0);
    wait_for(1, 300);
    wr(0, 8'h02);
    check(timer_running[1], 1'h0);
    held = cnt(1);
    cyc(30);
    check(cnt(1), held);
    // Stopwatch on timer 2, started through the mode start bit
    @(posedge clk_sys);
    timer_reload_high[23:16] <= 8'h01;
    use_stop_evt[2] <= 1'h1;
    pulse(1, 2);
    check(timer_running[2], 1'h1);
    cyc(60);
    pulse(3, 2);
    check(timer_running[2], 1'h0);
    held = cnt(2);
    check(held < 16'h0100, 1'h1);
    cyc(40);
    check(cnt(2), held);
    check(flag_register_b[2], 1'h0);
    check(flag_register_b[2], 1'h0);
    // Time-out on timer 3 that waits for its start event
    @(posedge clk_sys);
    wait_start_evt[3] <= 1'h1;
    timer_reload_low[31:24] <= 8'h03;
    wr(0, 8'h88);
    cyc(40);
    check(cnt(3), 16'h0003);
    pulse(2, 3);
    wait_for(3, 200);
    // Wake-up timer feeding timer 0
    @(posedge clk_sys);
    clk_sel[1:0] <= rtu_pkg::SEL_WAKE;
    timer_reload_low[7:0] <= 8'h01;
    wake_timer_auto_reload <= 1'h1;
    wr(0, 8'h11);
    pulse(4, 0);
    check(standby, 1'h1);
    pulse(5, 0);
    check(wake_running, 1'h1);
    check(wake_count, 16'h0002);
    @(posedge clk_sys);
    osc_on <= 1'h1;
    wait_for(5, 200);
    check(standby, 1'h0);
    check(cnt(0), 16'h0000);
    @(posedge clk_sys);
    osc_on <= 1'h0;
    cyc(2);
    pulse(6, 0);
    check(standby, 1'h0);
    @(posedge clk_sys);
    wake_timer_auto_standby <= 1'h1;
    pulse(6, 0);
    check(standby, 1'h1);
    check(wake_running, 1'h1);
    @(posedge clk_sys);
    card_present <= 1'h1;
    pulse(6, 0);
    check(flag_register_b[4], 1'h1);
    complete_run();
  end
endmodule
